// ---- src/usbirq_core.sv ----
// Interrupt flag register, enables, pin logic and pseudo frame timer
`timescale 1ns/100ps
// Function
// - Endpoint 14..1 events set flag bits 23..10.
// - Control IN sets bit 9, control OUT sets bit 8.
// - Bit 7 shows live bus sleep state, never latched or cleared.
// - Second and later consecutive missing frame starts set bit 5, pseudo tick every 1 ms.
// - Three consecutive missed frame starts raise a one-cycle sleep request (suspend_request_o).
// - Each detected frame start sets bit 4.
// - DMA counter reaching zero sets bit 3.
// - Awake to sleep transition sets bit 2.
// - Detected resume sets bit 1.
// - Detected bus reset sets bit 0.
// - Flags always log; enable bits gate them onto the pin.
// - Global enable cleared masks the interrupt pin entirely.
// - Polarity and level/pulse bits select pin form; reset low, level.
// - Pulse mode: one 175 ns (7-cycle) pulse on each rise of the enabled flag OR.
// - Flag read clears bus reset, resume, DMA done, frame start.
// - Endpoint flags clear only by reading that endpoint's status.
// - SETUP/OUT interrupts only after data packet acknowledged.
// - Bulk endpoints interrupt on every ACK sent or received.
// - Isochronous endpoints interrupt on every packet transaction.
// - Pseudo tick interrupt has its own enable bit.
module usbirq_core #(
	parameter int PSEUDO_FRAME_TICK_FLAG_PERIOD = usbirq_pkg::PSEUDO_FRAME_TICK_FLAG_CYCLES
) (
	input wire logic core_clk_i,
	input wire logic srst_i,
	// Endpoint traffic qualified by the SIE (acked, per transfer type)
	input wire logic [usbirq_pkg::NUM_EP-1:0] ep_event_i,
	input wire logic [usbirq_pkg::NUM_EP-1:0] ep_status_read_i,
	input wire logic sof_detect_i,
	input wire logic dma_count_zero_i,
	input wire logic bus_reset_detect_i,
	input wire logic resume_detect_i,
	input wire logic bus_sleep_pin_i,
	// Command port of the parallel interface
	input wire logic cmd_valid_i,
	input wire logic [7:0] cmd_code_i,
	input wire logic data_rd_i,
	output logic [7:0] data_o,
	// Configuration bits
	input wire logic [31:0] irq_enable_i,
	input wire logic global_irq_enable_i,
	input wire logic irq_pin_polarity_i,
	input wire logic irq_level_or_pulse_select_i,
	output logic live_bus_sleep_state_o,
	output logic suspend_request_o,
	output logic irq_o
);
	import usbirq_pkg::*;

	typedef struct packed {
		logic [31:0] flags;
		logic [2:0] sync;
		logic sleep;
		logic [31:0] snap;
		logic [1:0] byte_idx;
		usbirq_rd_e rd;
		logic [7:0] data;
		logic [31:0] pseudo_frame_tick_flag_cnt;
		logic [1:0] missed;
		logic missing;
		logic susp_req;
		logic any_d;
		logic trig;
		logic irq;
	} usbirq_st_s;

	usbirq_st_s st_reg;
	usbirq_st_s st_next;
	logic pulse;
	logic [31:0] set_vec;
	logic [31:0] clr_vec;
	logic any_irq;
	logic sleep_now;

	// ------------------------------------------------------------
	// Function: select byte from a 32-bit word
	// ------------------------------------------------------------
	function automatic logic [7:0] usbirq_byte(input logic [31:0] w, input logic [1:0] i);
		usbirq_byte = w[8*i +: 8];
	endfunction : usbirq_byte

	usbirq_pulse #(.LEN(PULSE_CYCLES)) u_pulse (
		.core_clk_i(core_clk_i),
		.srst_i(srst_i),
		.trig_i(st_reg.trig),
		.pulse_o(pulse)
	);

	always_comb begin
		st_next = st_reg;
		set_vec = '0;
		clr_vec = '0;
		// ------------------------------------------------------------
		// Bus sleep input synchroniser
		// ------------------------------------------------------------
		st_next.sync = {st_reg.sync[1:0], bus_sleep_pin_i};
		sleep_now = st_reg.sleep;
		if (st_reg.sync[1] == st_reg.sync[2]) begin
			sleep_now = st_reg.sync[2];
		end
		st_next.sleep = sleep_now;
		// ------------------------------------------------------------
		// Event capture
		// ------------------------------------------------------------
		set_vec[FLAG_EP_MSB:FLAG_CTL_OUT] = ep_event_i;
		set_vec[FLAG_SOF] = sof_detect_i;
		set_vec[FLAG_DMA_DONE] = dma_count_zero_i;
		set_vec[FLAG_SLEEP_ENTRY] = sleep_now && !st_reg.sleep;
		set_vec[FLAG_RESUME] = resume_detect_i;
		set_vec[FLAG_BUS_RESET] = bus_reset_detect_i;
		// ------------------------------------------------------------
		// Pseudo frame timer
		// ------------------------------------------------------------
		st_next.susp_req = 1'b0;
		if (sof_detect_i || st_reg.sleep) begin
			st_next.pseudo_frame_tick_flag_cnt = '0;
			st_next.missed = '0;
			st_next.missing = 1'b0;
		end else if (st_reg.pseudo_frame_tick_flag_cnt >= 32'(PSEUDO_FRAME_TICK_FLAG_PERIOD - 1)) begin
			st_next.pseudo_frame_tick_flag_cnt = '0;
			st_next.missing = 1'b1;
			set_vec[FLAG_PSEUDO_FRAME_TICK_FLAG] = st_reg.missing;
			if (st_reg.missed == 2'(MISSED_SOF_LIMIT - 1)) begin
				st_next.susp_req = 1'b1;
				st_next.missed = '0;
			end else begin
				st_next.missed = st_reg.missed + 2'h1;
			end
		end else begin
			st_next.pseudo_frame_tick_flag_cnt = st_reg.pseudo_frame_tick_flag_cnt + 32'h1;
		end
		// ------------------------------------------------------------
		// Read-flags command: four bytes, low byte first
		// ------------------------------------------------------------
		if (cmd_valid_i) begin
			if (cmd_code_i == CMD_READ_FLAGS) begin
				st_next.snap = st_reg.flags;
				st_next.snap[FLAG_SLEEP_STATE] = st_reg.sleep;
				st_next.byte_idx = '0;
				st_next.rd = USBIRQ_READ;
				st_next.data = usbirq_byte(st_next.snap, 2'h0);
				clr_vec = READ_CLEAR_MASK;
			end else begin
				st_next.rd = USBIRQ_IDLE;
			end
		end else begin
			case (st_reg.rd)
				USBIRQ_IDLE: begin
					st_next.rd = USBIRQ_IDLE;
				end
				USBIRQ_READ: begin
					if (data_rd_i) begin
						st_next.byte_idx = st_reg.byte_idx + 2'h1;
						st_next.data = usbirq_byte(st_reg.snap, st_reg.byte_idx + 2'h1);
						if (st_reg.byte_idx == 2'(FLAG_BYTES - 1)) begin
							st_next.rd = USBIRQ_DONE;
							st_next.data = '0;
						end
					end
				end
				USBIRQ_DONE: begin
					st_next.rd = USBIRQ_IDLE;
				end
				default: begin
					st_next.rd = USBIRQ_IDLE;
				end
			endcase
		end
		clr_vec[FLAG_EP_MSB:FLAG_CTL_OUT] = ep_status_read_i;
		// Set wins over clear
		st_next.flags = ((st_reg.flags & ~clr_vec) | set_vec) & STORE_MASK;
		// ------------------------------------------------------------
		// Interrupt pin
		// ------------------------------------------------------------
		any_irq = global_irq_enable_i && |(st_reg.flags & irq_enable_i);
		st_next.any_d = any_irq;
		st_next.trig = any_irq && !st_reg.any_d;
		if (irq_level_or_pulse_select_i) begin
			st_next.irq = any_irq ~^ irq_pin_polarity_i;
		end else begin
			st_next.irq = (pulse && global_irq_enable_i) ~^ irq_pin_polarity_i;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			st_reg <= '0;
			st_reg.flags <= FLAG_RESET_VAL;
			st_reg.rd <= USBIRQ_IDLE;
			st_reg.irq <= ~RST_IRQ_POL;
		end else begin
			st_reg <= st_next;
		end
	end

	assign data_o = st_reg.data;
	assign live_bus_sleep_state_o = st_reg.sleep;
	assign suspend_request_o = st_reg.susp_req;
	assign irq_o = st_reg.irq;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	property p_ep_set;
		@(posedge core_clk_i) disable iff (srst_i)
		ep_event_i[5] |=> st_reg.flags[FLAG_CTL_OUT + 5];
	endproperty
	a_ep_set: assert property (p_ep_set) else $error("endpoint flag not set");
	property p_ctl_in;
		@(posedge core_clk_i) disable iff (srst_i)
		ep_event_i[1] |=> st_reg.flags[FLAG_CTL_IN];
	endproperty
	a_ctl_in: assert property (p_ctl_in) else $error("control in flag not set");
	property p_sof;
		@(posedge core_clk_i) disable iff (srst_i)
		sof_detect_i |=> st_reg.flags[FLAG_SOF] && st_reg.pseudo_frame_tick_flag_cnt == 0;
	endproperty
	a_sof: assert property (p_sof) else $error("frame flag not set");
	property p_rdclr;
		@(posedge core_clk_i) disable iff (srst_i)
		cmd_valid_i && cmd_code_i == CMD_READ_FLAGS && !sof_detect_i && !dma_count_zero_i
		&& !resume_detect_i && !bus_reset_detect_i |=> (st_reg.flags & READ_CLEAR_MASK) == 0;
	endproperty
	a_rdclr: assert property (p_rdclr) else $error("read did not clear");
	property p_epkeep;
		@(posedge core_clk_i) disable iff (srst_i)
		st_reg.flags[FLAG_EP_LSB] && !ep_status_read_i[2] |=> st_reg.flags[FLAG_EP_LSB];
	endproperty
	a_epkeep: assert property (p_epkeep) else $error("endpoint flag lost");
	property p_dma;
		@(posedge core_clk_i) disable iff (srst_i)
		dma_count_zero_i |=> st_reg.flags[FLAG_DMA_DONE];
	endproperty
	a_dma: assert property (p_dma) else $error("dma flag not set");
	property p_gmask;
		@(posedge core_clk_i) disable iff (srst_i)
		!global_irq_enable_i |=> irq_o == ~$past(irq_pin_polarity_i);
	endproperty
	a_gmask: assert property (p_gmask) else $error("global mask failed");
	property p_lvl;
		@(posedge core_clk_i) disable iff (srst_i)
		irq_level_or_pulse_select_i && global_irq_enable_i && |(st_reg.flags & irq_enable_i)
		|=> irq_o == $past(irq_pin_polarity_i);
	endproperty
	a_lvl: assert property (p_lvl) else $error("level pin not active");
	property p_reg_clean;
		@(posedge core_clk_i) disable iff (srst_i)
		(st_reg.flags & ~STORE_MASK) == 0;
	endproperty
	a_reg_clean: assert property (p_reg_clean) else $error("reserved flag set");
	property p_live;
		@(posedge core_clk_i) disable iff (srst_i)
		st_reg.sync[1] == st_reg.sync[2] |=> live_bus_sleep_state_o == $past(st_reg.sync[2]);
	endproperty
	a_live: assert property (p_live) else $error("live sleep state stale");
	property p_snap7;
		@(posedge core_clk_i) disable iff (srst_i)
		cmd_valid_i && cmd_code_i == CMD_READ_FLAGS
		|=> st_reg.snap[FLAG_SLEEP_STATE] == $past(live_bus_sleep_state_o);
	endproperty
	a_snap7: assert property (p_snap7) else $error("sleep bit not live in read");
	property p_byte0;
		@(posedge core_clk_i) disable iff (srst_i)
		cmd_valid_i && cmd_code_i == CMD_READ_FLAGS |=> data_o == st_reg.snap[7:0];
	endproperty
	a_byte0: assert property (p_byte0) else $error("first byte not low byte");
	property p_entry;
		@(posedge core_clk_i) disable iff (srst_i)
		!live_bus_sleep_state_o ##1 live_bus_sleep_state_o |-> st_reg.flags[FLAG_SLEEP_ENTRY];
	endproperty
	a_entry: assert property (p_entry) else $error("sleep entry flag not set");
	property p_resume;
		@(posedge core_clk_i) disable iff (srst_i)
		resume_detect_i |=> st_reg.flags[FLAG_RESUME];
	endproperty
	a_resume: assert property (p_resume) else $error("resume flag not set");
	property p_brst;
		@(posedge core_clk_i) disable iff (srst_i)
		bus_reset_detect_i |=> st_reg.flags[FLAG_BUS_RESET];
	endproperty
	a_brst: assert property (p_brst) else $error("bus reset flag not set");
	property p_susp;
		@(posedge core_clk_i) disable iff (srst_i)
		suspend_request_o |-> st_reg.flags[FLAG_PSEUDO_FRAME_TICK_FLAG];
	endproperty
	a_susp: assert property (p_susp) else $error("sleep request without pseudo tick");
	property p_susp_once;
		@(posedge core_clk_i) disable iff (srst_i)
		suspend_request_o |=> !suspend_request_o;
	endproperty
	a_susp_once: assert property (p_susp_once) else $error("sleep request too long");
	property p_ep_clr;
		@(posedge core_clk_i) disable iff (srst_i)
		ep_status_read_i[2] && !ep_event_i[2] |=> !st_reg.flags[FLAG_EP_LSB];
	endproperty
	a_ep_clr: assert property (p_ep_clr) else $error("endpoint flag not cleared");
endmodule : usbirq_core

// ---- src/usbirq_pkg.sv ----
// Package: constants and types for the USB device interrupt logic
package usbirq_pkg;
	// ------------------------------------------------------------
	// Flag register layout
	// ------------------------------------------------------------
	localparam int FLAG_W = 32;
	localparam int FLAG_EP_LSB = 10;
	localparam int FLAG_EP_MSB = 23;
	localparam int FLAG_CTL_IN = 9;
	localparam int FLAG_CTL_OUT = 8;
	localparam int FLAG_SLEEP_STATE = 7;
	localparam int FLAG_PSEUDO_FRAME_TICK_FLAG = 5;
	localparam int FLAG_SOF = 4;
	localparam int FLAG_DMA_DONE = 3;
	localparam int FLAG_SLEEP_ENTRY = 2;
	localparam int FLAG_RESUME = 1;
	localparam int FLAG_BUS_RESET = 0;
	localparam int NUM_EP = 16;
	localparam logic [31:0] FLAG_RESET_VAL = 32'h0000_0000;
	// Flags cleared by reading the flag register
	localparam logic [31:0] READ_CLEAR_MASK = 32'h0000_001b;
	// Writable bits of the flag store (bit 7 is live, bit 6 and 31:24 reserved)
	localparam logic [31:0] STORE_MASK = 32'h00ff_ff3f;
	// ------------------------------------------------------------
	// Commands and timing
	// ------------------------------------------------------------
	localparam logic [7:0] CMD_READ_FLAGS = 8'hc0;
	localparam int FLAG_BYTES = 4;
	localparam int CLK_PERIOD_PS = 25000;
	localparam int PULSE_TIME_PS = 166000;
	// Least time rounds up
	localparam int PULSE_CYCLES = (PULSE_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int PSEUDO_FRAME_TICK_FLAG_TIME_US = 1000;
	localparam int PSEUDO_FRAME_TICK_FLAG_CYCLES = PSEUDO_FRAME_TICK_FLAG_TIME_US * 1000000 / CLK_PERIOD_PS;
	localparam int MISSED_SOF_LIMIT = 3;
	localparam logic RST_IRQ_POL = 1'b0;
	localparam logic RST_IRQ_LEVEL = 1'b1;
	typedef enum logic [2:0] {
		USBIRQ_IDLE = 3'b001,
		USBIRQ_READ = 3'b010,
		USBIRQ_DONE = 3'b100
	} usbirq_rd_e;
endpackage : usbirq_pkg

// ---- src/usbirq_pulse.sv ----
// Pulse stretcher: fixed-length high pulse from a one-cycle trigger
`timescale 1ns/100ps
module usbirq_pulse #(
	parameter int LEN = 7
) (
	input wire logic core_clk_i,
	input wire logic srst_i,
	input wire logic trig_i,
	output logic pulse_o
);
	typedef struct packed {
		logic [7:0] cnt;
		logic pulse;
	} usbirq_pl_s;
	usbirq_pl_s st_reg;
	usbirq_pl_s st_next;

	always_comb begin
		st_next = st_reg;
		if (trig_i) begin
			st_next.cnt = 8'(LEN - 1);
			st_next.pulse = 1'b1;
		end else if (st_reg.cnt != 8'h00) begin
			st_next.cnt = st_reg.cnt - 8'h01;
		end else begin
			st_next.pulse = 1'b0;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign pulse_o = st_reg.pulse;

	property p_len;
		@(posedge core_clk_i) disable iff (srst_i)
		trig_i |=> pulse_o [*7];
	endproperty
	a_len: assert property (p_len) else $error("pulse too short");
	property p_len_end;
		@(posedge core_clk_i) disable iff (srst_i)
		!trig_i [*7] |=> !pulse_o;
	endproperty
	a_len_end: assert property (p_len_end) else $error("pulse too long");
endmodule : usbirq_pulse

// ---- verification/usbirq_host.sv ----
// Host processor model: fetches the flag register over the command port
`timescale 1ns/100ps
module usbirq_host (
	input wire logic core_clk_i,
	input wire logic [7:0] data_i,
	output logic cmd_valid_o,
	output logic [7:0] cmd_code_o,
	output logic data_rd_o
);
	import usbirq_pkg::*;
	initial begin
		cmd_valid_o = 1'b0;
		cmd_code_o = 8'h00;
		data_rd_o = 1'b0;
	end
	// gap adds idle cycles before each byte, as a slow host would
	task automatic read_flags(input int gap, output logic [31:0] val);
		@(posedge core_clk_i);
		cmd_valid_o <= 1'b1;
		cmd_code_o <= CMD_READ_FLAGS;
		@(posedge core_clk_i);
		cmd_valid_o <= 1'b0;
		cmd_code_o <= ~CMD_READ_FLAGS;
		for (int i = 0; i < FLAG_BYTES; i++) begin
			repeat (gap) @(posedge core_clk_i);
			@(posedge core_clk_i);
			val[8*i +: 8] = data_i;
			data_rd_o <= 1'b1;
			@(posedge core_clk_i);
			data_rd_o <= 1'b0;
		end
	endtask : read_flags
	// Any other command, then a stray byte strobe; both must be ignored
	task automatic other_cmd(input logic [7:0] code);
		@(posedge core_clk_i);
		cmd_valid_o <= 1'b1;
		cmd_code_o <= code;
		@(posedge core_clk_i);
		cmd_valid_o <= 1'b0;
		data_rd_o <= 1'b1;
		@(posedge core_clk_i);
		data_rd_o <= 1'b0;
	endtask : other_cmd
endmodule : usbirq_host

// ---- verification/testbench.sv ----
// Self-checking bench for the interrupt flag logic
`timescale 1ns/100ps
module testbench;
	import usbirq_pkg::*;
	logic core_clk_i, srst_i, sof, dma, brst, res, sleep_pin, glob, pol, lvl, slp;
	logic cmd_valid, data_rd, sleep_o, susp_o, irq;
	logic [15:0] ep_ev, ep_st;
	logic [31:0] en, model, got;
	logic [7:0] cmd_code, data;
	int num_errors, checked, seed, n;
	usbirq_core #(.PSEUDO_FRAME_TICK_FLAG_PERIOD(20)) dut (.core_clk_i(core_clk_i), .srst_i(srst_i),
		.ep_event_i(ep_ev), .ep_status_read_i(ep_st), .sof_detect_i(sof),
		.dma_count_zero_i(dma), .bus_reset_detect_i(brst), .resume_detect_i(res),
		.bus_sleep_pin_i(sleep_pin), .cmd_valid_i(cmd_valid), .cmd_code_i(cmd_code),
		.data_rd_i(data_rd), .data_o(data), .irq_enable_i(en), .global_irq_enable_i(glob),
		.irq_pin_polarity_i(pol), .irq_level_or_pulse_select_i(lvl),
		.live_bus_sleep_state_o(sleep_o), .suspend_request_o(susp_o), .irq_o(irq));
	usbirq_host host (.core_clk_i(core_clk_i), .data_i(data), .cmd_valid_o(cmd_valid),
		.cmd_code_o(cmd_code), .data_rd_o(data_rd));
	initial begin
		core_clk_i = 1'b0;
		forever #12.5 core_clk_i = ~core_clk_i;
	end
	// ------------------------------------------------------------
	// Checking and stimulus tasks
	// ------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
		checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("FAIL at %0t: %s seen %h expected %h", $time, msg, seen, exp);
		end
	endtask : check
	task automatic fire(input logic [15:0] e, input logic [3:0] m);
		@(posedge core_clk_i);
		ep_ev <= e;
		{sof, dma, res, brst} <= m;
		@(posedge core_clk_i);
		ep_ev <= 16'h0000;
		{sof, dma, res, brst} <= 4'h0;
		model = model | {8'h00, e, 3'b000, m[3], m[2], 1'b0, m[1], m[0]};
	endtask : fire
	task automatic clear_ep(input logic [15:0] s);
		@(posedge core_clk_i);
		ep_st <= s;
		@(posedge core_clk_i);
		ep_st <= 16'h0000;
		model = model & ~{8'h00, s, 8'h00};
	endtask : clear_ep
	task automatic check_irq;
		logic act;
		repeat (4) @(posedge core_clk_i);
		@(negedge core_clk_i);
		act = glob & (|(model & en));
		check({31'h0, irq}, {31'h0, pol ? act : ~act}, "irq pin");
	endtask : check_irq
	task automatic read_check(input int gap);
		host.read_flags(gap, got);
		check(got, model | {24'h0, slp, 7'h0}, "flag read");
		model = model & ~READ_CLEAR_MASK;
	endtask : read_check
	task automatic give_verdict;
		$display("Comparisons %0d, mismatches %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : give_verdict
	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		seed = 55025;
		num_errors = 0;
		checked = 0;
		srst_i = 1'b1;
		ep_ev = 16'h0000;
		ep_st = 16'h0000;
		{sof, dma, res, brst, sleep_pin, glob, slp} = 7'h00;
		pol = RST_IRQ_POL;
		lvl = RST_IRQ_LEVEL;
		en = 32'h0000_0000;
		model = FLAG_RESET_VAL;
		repeat (3) @(posedge core_clk_i);
		srst_i <= 1'b0;
		repeat (2) @(posedge core_clk_i);
		@(negedge core_clk_i);
		check({31'h0, irq}, {31'h0, ~RST_IRQ_POL}, "idle pin after reset");
		read_check(0);
		// Sleeping bus holds the pseudo tick still during random traffic
		sleep_pin <= 1'b1;
		repeat (8) @(posedge core_clk_i);
		slp = 1'b1;
		model[FLAG_SLEEP_ENTRY] = 1'b1;
		check({31'h0, sleep_o}, 32'h1, "live sleep state");
		read_check(2);
		for (int k = 0; k < 24; k++) begin
			@(posedge core_clk_i);
			en <= 32'($random(seed)) & STORE_MASK;
			{pol, glob} <= 2'($random(seed));
			fire(16'($random(seed)), 4'($random(seed)));
			check_irq();
			if (k % 3 == 0) read_check(k % 2);
			else clear_ep(16'($random(seed)));
		end
		clear_ep(16'hffff);
		read_check(0);
		// Pulse mode, active high, one enabled source
		@(posedge core_clk_i);
		{lvl, pol, glob} <= 3'b011;
		en <= 32'h0000_0001;
		repeat (4) @(posedge core_clk_i);
		fire(16'h0000, 4'h1);
		n = 0;
		repeat (20) begin
			@(negedge core_clk_i);
			if (irq === 1'b1) n++;
		end
		check(n, PULSE_CYCLES, "pulse width");
		host.other_cmd(8'($random(seed)) | 8'h01);
		@(negedge core_clk_i);
		check({24'h0, data}, 32'h0, "ignored command");
		read_check(1);
		// Awake bus without frame starts: pseudo ticks then sleep request
		@(posedge core_clk_i);
		lvl <= 1'b1;
		en <= 32'h0000_0020;
		sleep_pin <= 1'b0;
		repeat (6) @(posedge core_clk_i);
		slp = 1'b0;
		n = 0;
		for (int k = 0; k < 200 && n == 0; k++) begin
			@(negedge core_clk_i);
			if (susp_o === 1'b1) n = 1;
		end
		check(n, 1, "sleep request after missed frames");
		model[FLAG_PSEUDO_FRAME_TICK_FLAG] = 1'b1;
		check_irq();
		read_check(0);
		@(posedge core_clk_i);
		en <= 32'h0000_001b;
		check_irq();
		// Frame start interrupt on, endpoint interrupts off, as for isochronous traffic
		fire(16'h0004, 4'h0);
		check_irq();
		fire(16'h0000, 4'h8);
		check_irq();
		give_verdict();
	end
endmodule : testbench
